// >>> rtl/cigf_core.sv
/*
  interrupt gating flags of the processor: global maskable gate, stack select
  and processor priority level, plus acceptance of pending requests.
  assumes request sources and the instruction sequencer share clk_sys_in,
  so no input passes a synchroniser.
*/
// Our own choices: the address map and the strobed register port.
// Functional notes
// - gate 0 blocks maskable requests, 1 allows
// - acknowledging any request clears the gate
// - stack select picks handler or task pointer
// - hardware acknowledge or trap 0-31 clears select
// - priority level is three bits, 0 to 7
// - accept maskable only at priority strictly above current level
// - reserved bit reads undefined, software writes zero
module cigf_core #(
  parameter int unsigned SP_W = 16
) (
  input  wire logic                       clk_sys_in,
  input  wire logic                       reset_n_in,
  // pending request from the interrupt sources
  input  wire logic                       irq_pending_in,
  input  wire logic                       irq_maskable_in,
  input  wire logic [cigf_pkg::PPL_W-1:0] irq_priority_in,
  // sequencer commands
  input  wire logic [2:0]                 cmd_in,
  input  wire logic [cigf_pkg::TRAP_W-1:0] trap_num_in,
  input  wire logic [cigf_pkg::FLG_W-1:0] restore_flags_in,
  input  wire logic [cigf_pkg::PPL_W-1:0] new_ppl_in,
  // stack pointer update from the sequencer
  input  wire logic                       sp_wr_in,
  input  wire logic [SP_W-1:0]            sp_wr_data_in,
  // register port
  input  wire logic [cigf_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [cigf_pkg::FLG_W-1:0] wdata_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  output logic      [cigf_pkg::FLG_W-1:0] rdata_out,
  // outputs to the sequencer
  output logic                            irq_accept_out,
  output logic                            gate_out,
  output logic                            stack_sel_out,
  output logic      [cigf_pkg::PPL_W-1:0] ppl_out,
  output logic      [SP_W-1:0]            active_sp_out
);

  // ***********************************************
  // flag state
  // ***********************************************
  logic                       gate_r;
  logic                       stack_sel_r;
  logic [cigf_pkg::PPL_W-1:0] ppl_r;
  logic                       rsvd_r;
  logic                       accept_now;
  logic                       trap_clears;
  logic                       flags_wr;
  cigf_pkg::cigf_cmd_t        cmd;
  logic [SP_W-1:0]            sp_rd;
  logic                       gate_nxt;
  logic                       stack_sel_nxt;
  logic [cigf_pkg::PPL_W-1:0] ppl_nxt;

  assign cmd = cigf_pkg::cigf_cmd_t'(cmd_in);

  function automatic logic [cigf_pkg::FLG_W-1:0] pack_flags(
    input logic                       g,
    input logic                       s,
    input logic [cigf_pkg::PPL_W-1:0] p,
    input logic                       rsv
  );
    logic [cigf_pkg::FLG_W-1:0] f;
    f = cigf_pkg::FLG_RESET;
    f[cigf_pkg::FLG_GATE_BIT]  = g;
    f[cigf_pkg::FLG_STACK_BIT] = s;
    f[cigf_pkg::FLG_RSVD_BIT]  = rsv;
    f[cigf_pkg::FLG_PPL_LSB +: cigf_pkg::PPL_W] = p;
    return f;
  endfunction : pack_flags

  // ***********************************************
  // acceptance
  // ***********************************************
  // non-maskable requests bypass gate and level
  assign accept_now = irq_pending_in &&
                      (!irq_maskable_in ||
                       (gate_r &&
                        (irq_priority_in > ppl_r)));
  assign trap_clears = (cmd == cigf_pkg::CIGF_CMD_TRAP) &&
                       (trap_num_in <= cigf_pkg::TRAP_MASKED_MAX);
  assign flags_wr = wr_in && (addr_in == cigf_pkg::REG_FLAGS);

  // ***********************************************
  // next-state: acknowledge beats sequencer and bus
  // ***********************************************
  always_comb begin
    gate_nxt      = gate_r;
    stack_sel_nxt = stack_sel_r;
    ppl_nxt       = ppl_r;
    if (flags_wr) begin
      gate_nxt      = wdata_in[cigf_pkg::FLG_GATE_BIT];
      stack_sel_nxt = wdata_in[cigf_pkg::FLG_STACK_BIT];
      ppl_nxt       = wdata_in[cigf_pkg::FLG_PPL_LSB +: cigf_pkg::PPL_W];
    end
    unique case (cmd)
      cigf_pkg::CIGF_CMD_NONE: begin
      end
      cigf_pkg::CIGF_CMD_TRAP: begin
        if (trap_clears) begin
          stack_sel_nxt = 1'b0;
        end
      end
      cigf_pkg::CIGF_CMD_RETURN: begin
        gate_nxt      = restore_flags_in[cigf_pkg::FLG_GATE_BIT];
        stack_sel_nxt = restore_flags_in[cigf_pkg::FLG_STACK_BIT];
        ppl_nxt       = restore_flags_in[cigf_pkg::FLG_PPL_LSB +: cigf_pkg::PPL_W];
      end
      cigf_pkg::CIGF_CMD_SET_GATE: begin
        gate_nxt = 1'b1;
      end
      cigf_pkg::CIGF_CMD_CLR_GATE: begin
        gate_nxt = 1'b0;
      end
      cigf_pkg::CIGF_CMD_LOAD_PPL: begin
        ppl_nxt = new_ppl_in;
      end
      default: begin
      end
    endcase
    if (accept_now) begin
      gate_nxt      = 1'b0;
      stack_sel_nxt = 1'b0;
      // the acknowledged level becomes the new floor
      ppl_nxt       = irq_priority_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      gate_r      <= 1'b0;
      stack_sel_r <= 1'b0;
      ppl_r       <= '0;
    end else begin
      gate_r      <= gate_nxt;
      stack_sel_r <= stack_sel_nxt;
      ppl_r       <= ppl_nxt;
    end
  end

  // reserved bit is held; flags reads return the fixed value, the status word bit 0 returns the held bit
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      rsvd_r <= 1'b0;
    end else if (flags_wr) begin
      rsvd_r <= wdata_in[cigf_pkg::FLG_RSVD_BIT];
    end
  end

  // ***********************************************
  // stack pointers
  // ***********************************************
  // writes go to the pointer selected now; the read follows the new select
  cigf_sp_bank #(
    .SP_W        (SP_W)
  ) u_sp_bank (
    .clk_sys_in  (clk_sys_in),
    .reset_n_in  (reset_n_in),
    .wr_en_in    (sp_wr_in),
    .wr_sel_in   (stack_sel_r),
    .wr_data_in  (sp_wr_data_in),
    .rd_sel_in   (stack_sel_nxt),
    .rd_data_out (sp_rd)
  );
  assign active_sp_out = sp_rd;

  // ***********************************************
  // outputs
  // ***********************************************
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      irq_accept_out <= 1'b0;
      gate_out       <= 1'b0;
      stack_sel_out  <= 1'b0;
      ppl_out        <= '0;
    end else begin
      irq_accept_out <= accept_now;
      gate_out       <= gate_nxt;
      stack_sel_out  <= stack_sel_nxt;
      ppl_out        <= ppl_nxt;
    end
  end

  // ***********************************************
  // register read port
  // ***********************************************
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      unique case (addr_in)
        cigf_pkg::REG_FLAGS:
          rdata_out <= pack_flags(gate_r, stack_sel_r, ppl_r,
                                  cigf_pkg::RSVD_READ_VAL[0]);
        cigf_pkg::REG_STATUS:
          rdata_out <= {13'h0, irq_pending_in, accept_now, rsvd_r};
        default:
          rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

endmodule : cigf_core

// >>> rtl/cigf_sp_bank.sv
/*
  two-entry stack pointer store, handler and task, with registered read.
  assumes its caller keeps one clock and gives one write per cycle at most.
*/
module cigf_sp_bank #(
  parameter int unsigned SP_W = 16
) (
  input  wire logic            clk_sys_in,
  input  wire logic            reset_n_in,
  input  wire logic            wr_en_in,
  input  wire logic            wr_sel_in,
  input  wire logic [SP_W-1:0] wr_data_in,
  input  wire logic            rd_sel_in,
  output logic      [SP_W-1:0] rd_data_out
);

  logic [SP_W-1:0] mem_r [2];

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else if (wr_en_in) begin
      mem_r[wr_sel_in] <= wr_data_in;
    end
  end

  // read data come a cycle late so callers see a plain register
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_r[rd_sel_in];
    end
  end

endmodule : cigf_sp_bank

// >>> shared/cigf_pkg.sv
/*
  package for the processor interrupt gating flags block: flag register layout,
  reset values, command encodings and register offsets.
  assumes a single core clock domain and a synchronous active-low reset.
*/
package cigf_pkg;

  // ***********************************************
  // flag register layout (16-bit word)
  // ***********************************************
  localparam int unsigned FLG_W          = 16;
  localparam int unsigned FLG_GATE_BIT   = 6;
  localparam int unsigned FLG_STACK_BIT  = 7;
  localparam int unsigned FLG_RSVD_BIT   = 11;
  localparam int unsigned FLG_PPL_LSB    = 12;
  localparam int unsigned PPL_W          = 3;
  localparam int unsigned TRAP_W         = 6;
  localparam logic [5:0]  TRAP_MASKED_MAX = 6'h1F;

  localparam logic [15:0] FLG_RESET      = 16'h0000;
  localparam logic [15:0] FLG_WMASK      = 16'h70C0;

  // ***********************************************
  // register bus map
  // ***********************************************
  localparam int unsigned ADDR_W         = 4;
  localparam logic [3:0]  REG_FLAGS      = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h1;
  localparam logic [3:0]  REG_HSP        = 4'h2;
  localparam logic [3:0]  REG_TSP        = 4'h3;
  localparam logic [15:0] RSVD_READ_VAL  = 16'h0000;

  // ***********************************************
  // sequencer commands
  // ***********************************************
  typedef enum logic [2:0] {
    CIGF_CMD_NONE,
    CIGF_CMD_TRAP,
    CIGF_CMD_RETURN,
    CIGF_CMD_SET_GATE,
    CIGF_CMD_CLR_GATE,
    CIGF_CMD_LOAD_PPL
  } cigf_cmd_t;

endpackage : cigf_pkg

// >>> verification/cigf_irq_src.sv
/* request source model: holds a request until it is taken or withdrawn.
   assumes the clock and reset of the block. */
module cigf_irq_src (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  input  wire logic       raise_in,
  input  wire logic       drop_in,
  input  wire logic [2:0] prio_in,
  input  wire logic       accept_in,
  output logic            pending_out,
  output logic      [2:0] prio_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // request line
  // ******
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      {pending_out, prio_out} <= 4'h0;
    end else if (raise_in) begin
      {pending_out, prio_out} <= {1'b1, prio_in};
    end else if (drop_in || accept_in) begin
      pending_out <= 1'b0;
    end else if (!pending_out) begin
      prio_out <= ~prio_out;  // idle lines never hold a stale level
    end
  end
endmodule : cigf_irq_src

// >>> verification/cigf_properties.sv
/* port assertions for the interrupt gating flags block.
   assumes one clock and a synchronous active-low reset. */
module cigf_properties (
  input wire logic                        clk_sys_in,
  input wire logic                        reset_n_in,
  input wire logic                        irq_pending_in,
  input wire logic                        irq_maskable_in,
  input wire logic [cigf_pkg::PPL_W-1:0]  irq_priority_in,
  input wire logic [2:0]                  cmd_in,
  input wire logic [cigf_pkg::TRAP_W-1:0] trap_num_in,
  input wire logic                        irq_accept_out,
  input wire logic                        gate_out,
  input wire logic                        stack_sel_out,
  input wire logic [cigf_pkg::PPL_W-1:0]  ppl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // properties
  // ******
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  logic mreq;
  assign mreq = irq_pending_in && irq_maskable_in;
  a_gate_blocks: assert property (mreq && !gate_out |=> !irq_accept_out)
    else $error("accept with gate closed");
  a_gate_admits: assert property (mreq && gate_out && irq_priority_in > ppl_out |=> irq_accept_out)
    else $error("open gate request not taken");
  a_ack_gate: assert property (irq_accept_out |-> !gate_out)
    else $error("gate still open after accept");
  a_ack_select: assert property (irq_accept_out |-> !stack_sel_out)
    else $error("select kept after accept");
  a_trap_select: assert property (cmd_in == 3'h1 && trap_num_in <= 6'h1F |=> !stack_sel_out)
    else $error("select kept after low trap");
  a_ack_level: assert property (irq_accept_out |-> ppl_out == $past(irq_priority_in))
    else $error("level not loaded on accept");
  a_prio_strict: assert property (mreq && irq_priority_in <= ppl_out |=> !irq_accept_out)
    else $error("accept at or below level");
  c_accept: cover property (irq_accept_out);
  c_equal_level: cover property (mreq && gate_out && irq_priority_in == ppl_out);
  c_trap_edge: cover property (cmd_in == 3'h1 && trap_num_in == 6'h1F);
endmodule : cigf_properties

// >>> verification/testbench.sv
/* self-checking bench for the gating flags block.
   assumes the request source model drives the request lines. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // stimulus
  // ******
  logic        clk_sys_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        raise = 1'b0, drop = 1'b0, sp_wr = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [2:0]  rprio = 3'h0, cmd = 3'h0, new_ppl = 3'h0;
  logic [5:0]  trap = 6'h00;
  logic [15:0] sp_data = 16'h0000, wdata = 16'h0000, rdata, sp;
  logic [3:0]  addr = 4'h0;
  logic        mask = 1'b1;
  logic [15:0] rflags = 16'h0000;
  logic        pend, acc, gate, sel;
  logic [2:0]  prio, ppl;
  int          n_errors = 0, cmp_count = 0, cyc = 0;
  `define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("FAIL %s exp %0h got %0h", n, e, a); end end
  always #5 clk_sys_in = ~clk_sys_in;
  cigf_irq_src u_src (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .raise_in(raise),
    .drop_in(drop), .prio_in(rprio), .accept_in(acc), .pending_out(pend), .prio_out(prio));
  cigf_core u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .irq_pending_in(pend),
    .irq_maskable_in(mask), .irq_priority_in(prio), .cmd_in(cmd), .trap_num_in(trap),
    .restore_flags_in(rflags), .new_ppl_in(new_ppl), .sp_wr_in(sp_wr),
    .sp_wr_data_in(sp_data), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .irq_accept_out(acc), .gate_out(gate), .stack_sel_out(sel),
    .ppl_out(ppl), .active_sp_out(sp));
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : tick
  task automatic wr_reg(logic [3:0] a, logic [15:0] d);
    {addr, wdata, wr} <= {a, d, 1'b1};
    tick(1);
    wr <= 1'b0;
    tick(1);
  endtask : wr_reg
  task automatic rd_reg(logic [3:0] a, logic [15:0] e, string n);
    {addr, rd} <= {a, 1'b1};
    tick(1);
    rd <= 1'b0;
    tick(1);
    `CHK(n, e, rdata)
  endtask : rd_reg
  task automatic seq(logic [2:0] c, logic [5:0] t, logic [2:0] l);
    {cmd, trap, new_ppl} <= {c, t, l};
    tick(1);
    cmd <= 3'h0;
    tick(2);
  endtask : seq
  task automatic sp_put(logic [15:0] d);
    {sp_data, sp_wr} <= {d, 1'b1};
    tick(1);
    sp_wr <= 1'b0;
    tick(2);
  endtask : sp_put
  task automatic request(logic [2:0] p, logic e, string n);
    logic got;
    got = 1'b0;
    {rprio, raise} <= {p, 1'b1};
    tick(1);
    raise <= 1'b0;
    repeat (4) begin
      tick(1);
      if (acc === 1'b1) got = 1'b1;
    end
    `CHK(n, e, got)
    drop <= 1'b1;
    tick(1);
    drop <= 1'b0;
    tick(1);
  endtask : request
  task automatic t_gate();
    `CHK("reset flags", 1'b0, gate | sel | (|ppl))
    rd_reg(cigf_pkg::REG_FLAGS, 16'h0000, "flags reset");
    request(3'h3, 1'b0, "gate closed");
    wr_reg(cigf_pkg::REG_FLAGS, 16'h00C0);
    request(3'h3, 1'b1, "gate open");
    `CHK("gate cleared", 1'b0, gate)
    `CHK("select cleared", 1'b0, sel)
    `CHK("level loaded", 3'h3, ppl)
  endtask : t_gate
  task automatic t_prio();
    wr_reg(cigf_pkg::REG_FLAGS, 16'h3040);
    request(3'h3, 1'b0, "equal level");
    request(3'h4, 1'b1, "above level");
    seq(cigf_pkg::CIGF_CMD_LOAD_PPL, 6'h00, 3'h7);
    rd_reg(cigf_pkg::REG_FLAGS, 16'h7000, "level seven");
    wr_reg(cigf_pkg::REG_FLAGS, 16'h7040);
    request(3'h7, 1'b0, "top level");
  endtask : t_prio
  task automatic t_stack();
    wr_reg(cigf_pkg::REG_FLAGS, 16'h0000);
    sp_put(16'hA5A5);
    wr_reg(cigf_pkg::REG_FLAGS, 16'h0080);
    sp_put(16'h5A5A);
    `CHK("task pointer", 16'h5A5A, sp)
    seq(cigf_pkg::CIGF_CMD_TRAP, 6'h20, 3'h0);
    `CHK("trap 32 select", 1'b1, sel)
    seq(cigf_pkg::CIGF_CMD_TRAP, 6'h1F, 3'h0);
    `CHK("trap 31 select", 1'b0, sel)
    `CHK("handler pointer", 16'hA5A5, sp)
  endtask : t_stack
  task automatic t_rsvd();
    wr_reg(cigf_pkg::REG_FLAGS, 16'h08C0);
    rd_reg(cigf_pkg::REG_FLAGS, 16'h00C0, "reserved bit");
    rd_reg(4'h2, 16'h0000, "unmapped read");
    rd_reg(cigf_pkg::REG_STATUS, 16'h0001, "status word");
  endtask : t_rsvd
  task automatic t_seq();
    wr_reg(cigf_pkg::REG_FLAGS, 16'h0000);
    seq(cigf_pkg::CIGF_CMD_SET_GATE, 6'h00, 3'h0);
    `CHK("gate set cmd", 1'b1, gate)
    seq(cigf_pkg::CIGF_CMD_CLR_GATE, 6'h00, 3'h0);
    `CHK("gate clear cmd", 1'b0, gate)
    rflags <= 16'h50C0;
    seq(cigf_pkg::CIGF_CMD_RETURN, 6'h00, 3'h0);
    rd_reg(cigf_pkg::REG_FLAGS, 16'h50C0, "return restore");
    seq(cigf_pkg::CIGF_CMD_CLR_GATE, 6'h00, 3'h0);
    mask <= 1'b0;
    request(3'h2, 1'b1, "non-maskable");
    mask <= 1'b1;
    `CHK("non-maskable level", 3'h2, ppl)
    `CHK("non-maskable select", 1'b0, sel)
  endtask : t_seq
  task automatic tally_and_finish();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 1000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    tick(5);
    reset_n_in <= 1'b1;
    tick(1);
    t_gate();
    t_prio();
    t_stack();
    t_rsvd();
    t_seq();
    tally_and_finish();
  end
endmodule : testbench
bind cigf_core cigf_properties u_props (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
  .irq_pending_in(irq_pending_in), .irq_maskable_in(irq_maskable_in),
  .irq_priority_in(irq_priority_in), .cmd_in(cmd_in), .trap_num_in(trap_num_in),
  .irq_accept_out(irq_accept_out), .gate_out(gate_out), .stack_sel_out(stack_sel_out),
  .ppl_out(ppl_out));
